// ---- hw/pad_pkg.sv ----
// Shared constants and types for the pipelined converter digital interface.
// Assumes one 40 MHz system clock and a plain strobe register port.
`default_nettype none

package pad_pkg;

	// Result word and core input widths
	localparam int PAD_DATA_W = 12;
	localparam int PAD_IN_W = 14;
	// Rising sample edges between taking a sample and its output edge
	localparam int PAD_LATENCY = 5;

	// Register port widths
	localparam int PAD_ADDR_W = 4;
	localparam int PAD_REG_W = 8;

	// Register offsets
	localparam logic [3:0] PAD_OFF_STATUS = 4'h0;
	localparam logic [3:0] PAD_OFF_MASK = 4'h4;
	localparam logic [3:0] PAD_OFF_MODE = 4'h8;

	// Event bit positions, shared by status and mask
	localparam int PAD_EV_OVER = 0;
	localparam int PAD_EV_MODE = 1;
	localparam int PAD_EV_STBY = 2;
	localparam int PAD_EV_W = 3;

	// Mode register field positions
	localparam int PAD_MF_MODE = 0;
	localparam int PAD_MF_REFINT = 2;
	localparam int PAD_MF_FRESH = 3;

	// Reset values
	localparam logic [PAD_EV_W-1:0] PAD_MASK_RST = 3'h0;
	localparam logic [PAD_EV_W-1:0] PAD_STATUS_RST = 3'h0;

	// Mode pin codes, high pin first
	localparam logic [1:0] PAD_PINS_GAIN_X1 = 2'h1;
	localparam logic [1:0] PAD_PINS_GAIN_HALF = 2'h2;

	// In-range limits of the scaled differential value
	localparam logic signed [PAD_IN_W-1:0] PAD_FS_POS = 14'sh07ff;
	localparam logic signed [PAD_IN_W-1:0] PAD_FS_NEG = 14'sh3800;

	// Operating modes
	typedef enum logic [1:0] {
		PAD_ST_STANDBY,
		PAD_ST_GAIN_X1,
		PAD_ST_GAIN_HALF
	} pad_mode_t;

endpackage

`default_nettype wire

// ---- hw/pad_sync.sv ----
// Two-stage synchroniser for a group of unrelated level inputs.
// Assumes each bit is a slow level or a clock well below ref_clk.
`default_nettype none

module pad_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg; // First stage, read only by the second
	logic [W-1:0] sync_reg; // Second stage

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (W < 1) begin : g_chk
		$error("pad_sync width must be at least one");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two flip-flops in series
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

`default_nettype wire

// ---- hw/pad_delay.sv ----
// Shift-enabled delay line holding converted words between sample edges.
// Assumes shift_en is a one-cycle pulse on the same clock.
`default_nettype none

module pad_delay #(
	parameter int W = 13,
	parameter int DEPTH = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Shift control and data
	input wire logic shift_en,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] pipe_reg [DEPTH]; // Stage storage, index 0 is the newest
	logic [W-1:0] pipe_next [DEPTH]; // Next stage values

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (DEPTH < 1 || W < 1) begin : g_chk
		$error("pad_delay needs at least one stage and one bit");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Advance every stage on a shift
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			pipe_next[i] = pipe_reg[i];
		end
		if (shift_en) begin
			pipe_next[0] = din;
			for (int i = 1; i < DEPTH; i++) begin
				pipe_next[i] = pipe_reg[i-1];
			end
		end
	end

	// Register the stages
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe_reg[i] <= '0;
			end
		end else begin
			pipe_reg <= pipe_next;
		end
	end

	assign dout = pipe_reg[DEPTH-1];

endmodule

`default_nettype wire

// ---- hw/pad_adc_if.sv ----
// Digital control and output side of a 12-bit pipelined sampling converter.
// Assumes the sample clock and mode pins are asynchronous to ref_clk,
// the sample clock stays below a third of ref_clk, and the core quantiser
// presents its differential value on ref_clk.
// Behaviour
// - Both mode pins low: standby, no conversion
// - Mode codes select gain one or half
// - Enable high tri-states the twelve data outputs
// - Data enable acts without the clock
// - Sample taken on every rising sample edge outside standby
// - Result follows five rising edges later
// - Outputs change only after a falling edge
// - Result is twelve parallel bits
// - Unsigned binary, zero at negative end
// - Over-range flag aligned with its result
// - Span doubles at gain half, scales reference
//
// Implementation choices: the address-and-strobe port and the register addresses.
`default_nettype none

module pad_adc_if
	import pad_pkg::*;
#(
	parameter int LATENCY = PAD_LATENCY
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Converter pins from the far side
	input wire logic sample_clk,
	input wire logic mode_select_low,
	input wire logic mode_select_high,
	input wire logic ref_source_select,
	input wire logic out_en_n,
	// Quantised differential value from the core
	input wire logic signed [PAD_IN_W-1:0] diff_in,
	// Result pins
	output logic [PAD_DATA_W-1:0] data_out,
	output logic [PAD_DATA_W-1:0] data_oe,
	output logic over_range_flag,
	// Front-end control
	output logic standby,
	output logic ref_internal_en,
	// Register port
	input wire logic [PAD_ADDR_W-1:0] reg_addr,
	input wire logic [PAD_REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [PAD_REG_W-1:0] reg_rdata,
	// Interrupt
	output logic irq
);

	localparam int CNT_W = $clog2(LATENCY + 1); // Fill counter width
	localparam int WORD_W = PAD_DATA_W + 1; // Over flag plus code

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (LATENCY < 1 || LATENCY > 15) begin : g_chk
		$error("pad_adc_if latency must lie between 1 and 15");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [3:0] pins_sync; // Sample clock, mode high, mode low, reference select
	logic sclk_s; // Synchronised sample clock
	logic mode_hi_s; // Synchronised mode high pin
	logic mode_lo_s; // Synchronised mode low pin
	logic ref_sel_s; // Synchronised reference select

	pad_sync #(
		.W(4)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async_in({sample_clk, mode_select_high, mode_select_low, ref_source_select}),
		.sync_out(pins_sync)
	);

	assign sclk_s = pins_sync[3];
	assign mode_hi_s = pins_sync[2];
	assign mode_lo_s = pins_sync[1];
	assign ref_sel_s = pins_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// Sample clock edges and mode
	logic sclk_prev_reg; // Last synchronised sample clock level
	pad_mode_t mode_reg; // Current operating mode
	pad_mode_t mode_next;
	logic ref_int_reg; // Internal reference buffer enabled
	logic ref_int_next;
	logic rise_pulse; // Rising sample edge seen
	logic fall_pulse; // Falling sample edge seen
	logic active; // Converting, not in standby
	logic shift_en; // Take one sample

	assign rise_pulse = sclk_s & ~sclk_prev_reg;
	assign fall_pulse = ~sclk_s & sclk_prev_reg;
	assign active = (mode_reg != PAD_ST_STANDBY);
	assign shift_en = rise_pulse & active;

	// Decode mode pins; the unused code falls to standby
	always_comb begin
		ref_int_next = ~ref_sel_s;
		case ({mode_hi_s, mode_lo_s})
			PAD_PINS_GAIN_X1: begin
				mode_next = PAD_ST_GAIN_X1;
			end
			PAD_PINS_GAIN_HALF: begin
				mode_next = PAD_ST_GAIN_HALF;
			end
			default: begin
				mode_next = PAD_ST_STANDBY;
			end
		endcase
	end

	// Register mode and edge history
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_reg <= 1'b0;
			mode_reg <= PAD_ST_STANDBY;
			ref_int_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
			mode_reg <= mode_next;
			ref_int_reg <= ref_int_next;
		end
	end

	assign standby = (mode_reg == PAD_ST_STANDBY);
	assign ref_internal_en = ref_int_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion to unsigned code
	logic signed [PAD_IN_W-1:0] scaled; // Value after sample-and-hold gain
	logic signed [PAD_IN_W-1:0] biased; // Value shifted to offset binary
	logic conv_over; // Value beyond the reference span
	logic [PAD_DATA_W-1:0] conv_code; // Clamped unsigned code

	always_comb begin
		// Gain half doubles the accepted span
		if (mode_reg == PAD_ST_GAIN_HALF) begin
			scaled = diff_in >>> 1;
		end else begin
			scaled = diff_in;
		end
		biased = scaled - PAD_FS_NEG;
		conv_over = (scaled > PAD_FS_POS) || (scaled < PAD_FS_NEG);
		// Clamp to the end codes when out of span
		if (!conv_over) begin
			conv_code = biased[PAD_DATA_W-1:0];
		end else if (scaled > PAD_FS_POS) begin
			conv_code = '1;
		end else begin
			conv_code = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pipeline and output registers
	logic [WORD_W-1:0] tail; // Oldest word in the pipeline
	logic [WORD_W-1:0] ready_reg; // Word due at the next falling edge
	logic [WORD_W-1:0] ready_next;
	logic [WORD_W-1:0] out_reg; // Word on the pins
	logic [WORD_W-1:0] out_next;
	logic [CNT_W-1:0] fill_reg; // Samples taken under the current mode
	logic [CNT_W-1:0] fill_next;
	logic mode_change; // Decoded pin mode differs from the registered mode

	pad_delay #(
		.W(WORD_W),
		.DEPTH(LATENCY)
	) u_pipe (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.shift_en(shift_en),
		.din({conv_over, conv_code}),
		.dout(tail)
	);

	assign mode_change = (mode_next != mode_reg);

	// Move words along; publish only on falling edges
	always_comb begin
		ready_next = ready_reg;
		out_next = out_reg;
		fill_next = fill_reg;
		if (shift_en) begin
			ready_next = tail;
		end
		if (fall_pulse) begin
			out_next = ready_reg;
		end
		// Count samples so software sees when old ones have drained
		if (mode_change) begin
			fill_next = '0;
		end else if (shift_en && fill_reg < CNT_W'(LATENCY)) begin
			fill_next = fill_reg + CNT_W'(1);
		end
	end

	// Register pipeline outputs
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ready_reg <= '0;
			out_reg <= '0;
			fill_reg <= '0;
		end else begin
			ready_reg <= ready_next;
			out_reg <= out_next;
			fill_reg <= fill_next;
		end
	end

	// Output buffers switch with the enable pin, not the clock
	assign data_out = out_reg[PAD_DATA_W-1:0];
	assign data_oe = {PAD_DATA_W{~out_en_n}};
	assign over_range_flag = out_reg[PAD_DATA_W];

	////////////////////////////////////////////////////////////////////////////////
	// Registers and interrupt
	logic [PAD_EV_W-1:0] status_reg; // Sticky events
	logic [PAD_EV_W-1:0] status_next;
	logic [PAD_EV_W-1:0] mask_reg; // Interrupt enables
	logic [PAD_EV_W-1:0] mask_next;
	logic [PAD_REG_W-1:0] rdata_reg; // Read answer, one cycle only
	logic [PAD_REG_W-1:0] rdata_next;
	logic [PAD_EV_W-1:0] events; // Events of this cycle
	logic [PAD_REG_W-1:0] mode_word; // Mode register contents

	always_comb begin
		events = '0;
		events[PAD_EV_OVER] = fall_pulse & ready_reg[PAD_DATA_W];
		events[PAD_EV_MODE] = mode_change;
		events[PAD_EV_STBY] = mode_change & (mode_next == PAD_ST_STANDBY);
		mode_word = '0;
		mode_word[PAD_MF_MODE +: 2] = mode_reg;
		mode_word[PAD_MF_REFINT] = ref_int_reg;
		mode_word[PAD_MF_FRESH] = (fill_reg == CNT_W'(LATENCY));
		status_next = status_reg;
		mask_next = mask_reg;
		rdata_next = '0;
		// Address decode for reads; a status read clears, new events win
		if (reg_rd) begin
			if (reg_addr == PAD_OFF_STATUS) begin
				rdata_next = PAD_REG_W'(status_reg);
				status_next = '0;
			end else if (reg_addr == PAD_OFF_MASK) begin
				rdata_next = PAD_REG_W'(mask_reg);
			end else if (reg_addr == PAD_OFF_MODE) begin
				rdata_next = mode_word;
			end else begin
				rdata_next = '0;
			end
		end
		// Only the mask is writable
		if (reg_wr && reg_addr == PAD_OFF_MASK) begin
			mask_next = reg_wdata[PAD_EV_W-1:0];
		end
		status_next = status_next | events;
	end

	// Register the software-visible state
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			status_reg <= PAD_STATUS_RST;
			mask_reg <= PAD_MASK_RST;
			rdata_reg <= '0;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_take;
		rise_pulse && active;
	endsequence

	sequence s_idle2;
		(mode_reg == PAD_ST_STANDBY) [*2];
	endsequence

	a_standby_frozen: assert property (s_idle2 |-> $stable(tail) && $stable(ready_reg))
		else $error("pipeline moved in standby");

	a_gain_half: assert property (
		(mode_reg == PAD_ST_GAIN_HALF && diff_in == 14'sh03e8) |-> conv_code == 12'h9f4)
		else $error("gain half code wrong");

	a_gain_one: assert property (
		(mode_reg == PAD_ST_GAIN_X1 && diff_in == 14'sh03e8) |-> conv_code == 12'hbe8)
		else $error("gain one code wrong");

	a_code_ends: assert property (
		(mode_reg == PAD_ST_GAIN_X1 && diff_in == 14'sh3800) |-> conv_code == 12'h000 && !conv_over)
		else $error("bottom code wrong");

	a_over_top: assert property (
		(mode_reg == PAD_ST_GAIN_X1 && diff_in == 14'sh0800) |-> conv_over && conv_code == 12'hfff)
		else $error("over-range not flagged");

	a_half_span: assert property (
		(mode_reg == PAD_ST_GAIN_HALF && diff_in == 14'sh0fff) |-> !conv_over && conv_code == 12'hfff)
		else $error("gain half span wrong");

	a_oe_on: assert property ($fell(out_en_n) |-> data_oe == '1)
		else $error("outputs not driven after enable");

	a_oe_off: assert property ($rose(out_en_n) |-> data_oe == '0)
		else $error("outputs still driven after disable");

	a_take_count: assert property (
		s_take ##0 (!mode_change && fill_reg < CNT_W'(LATENCY)) |=> fill_reg == $past(fill_reg) + 1)
		else $error("sample edge not taken");

	a_ready_load: assert property (s_take |=> ready_reg == $past(tail))
		else $error("result not advanced on sample edge");

	a_publish_fall: assert property ($changed(out_reg) |-> $past(fall_pulse))
		else $error("outputs changed without falling edge");

	a_irq_level: assert property ((status_reg & mask_reg) != '0 |-> irq)
		else $error("interrupt missing");

endmodule

`default_nettype wire

// ---- test/pad_capture_model.sv ----
// Far-side capture model: makes the sample clock and latches each result.
// Assumes it sees the result pins as resolved wire levels.
`default_nettype none

module pad_capture_model (
	// Sample clock to the converter
	output logic sample_clk,
	// Resolved result pins and the mode pins the bench drives elsewhere
	input wire logic [11:0] data_pin,
	input wire logic over_pin,
	input wire logic [1:0] mode_pins,
	// Captured view for the bench
	output logic [11:0] cap_word,
	output logic cap_over,
	output int rise_cnt,
	output logic cap_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] last_mode; // Mode seen at the previous rise
	int fresh_cnt; // Rises since the mode last changed

	////////////////////////////////////////////////////////////////////////////
	// Continuous sample clock, about 3.3 MHz, phase offset from ref_clk
	initial begin
		sample_clk = 1'b0;
		cap_word = 12'h000;
		cap_over = 1'b0;
		rise_cnt = 0;
		fresh_cnt = 0;
		last_mode = 2'h0;
		#7;
		forever #150 sample_clk = ~sample_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Latch on each rise; the rise count lets words line up six samples back
	always @(posedge sample_clk) begin
		rise_cnt <= rise_cnt + 1;
		cap_word <= data_pin;
		cap_over <= over_pin;
		last_mode <= mode_pins;
		fresh_cnt <= (mode_pins != last_mode) ? 0 : fresh_cnt + 1;
	end

	// Words from before a mode change are still in the pipe: not valid yet
	assign cap_valid = fresh_cnt > 5;

endmodule

`default_nettype wire

// ---- test/pad_adc_if_test.sv ----
// Self-checking bench for the converter digital interface.
// Assumes the capture model drives the sample clock; the bench drives the rest.
`default_nettype none

module pad_adc_if_test;
	import pad_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk = 1'b0; // 40 MHz system clock
	logic rstn, sample_clk, mode_select_low, mode_select_high, ref_source_select, out_en_n;
	logic signed [PAD_IN_W-1:0] diff_in; // Core value
	logic [PAD_DATA_W-1:0] data_out, data_oe, data_pin;
	logic over_range_flag, standby, ref_internal_en, reg_wr, reg_rd, irq;
	logic [PAD_ADDR_W-1:0] reg_addr;
	logic [PAD_REG_W-1:0] reg_wdata, reg_rdata;
	logic [11:0] cap_word;
	logic cap_over, cap_valid;
	logic [15:0] save; // Held output while frozen
	int rise_cnt, err_count, checks_done, k;
	int vals[10] = '{2048, -2049, -2048, 2047, 0, 4095, 4096, -4096, -4098, 1000};

	always #12.5 ref_clk = ~ref_clk;

	// Released pins show the inverse of the last driven value
	assign data_pin = (data_oe & data_out) | (~data_oe & ~data_out);

	pad_adc_if #(.LATENCY(PAD_LATENCY)) DUT (.ref_clk(ref_clk), .rstn(rstn),
		.sample_clk(sample_clk), .mode_select_low(mode_select_low),
		.mode_select_high(mode_select_high), .ref_source_select(ref_source_select),
		.out_en_n(out_en_n), .diff_in(diff_in), .data_out(data_out), .data_oe(data_oe),
		.over_range_flag(over_range_flag), .standby(standby),
		.ref_internal_en(ref_internal_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	pad_capture_model far_end (.sample_clk(sample_clk), .data_pin(data_pin),
		.over_pin(over_range_flag), .mode_pins({mode_select_high, mode_select_low}),
		.cap_word(cap_word), .cap_over(cap_over), .rise_cnt(rise_cnt),
		.cap_valid(cap_valid));

	////////////////////////////////////////////////////////////////////////////
	// Expected {flag, code}: halve at gain half, offset by mid-scale, clamp
	function automatic logic [15:0] conv(input int v, input bit half);
		int s;
		s = half ? (v >>> 1) : v;
		if (s > 2047) return 16'h1fff;
		if (s < -2048) return 16'h1000;
		return 16'(s + 2048);
	endfunction

	task automatic results();
		$display("err_count %0d checks_done %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Compare a port value
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read, then compare the bits under the mask
	task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] d;
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata & m;
		chk_val(16'(d), 16'(exp));
	endtask

	// Bounded wait until the capture model has seen a given rise count
	task automatic wait_to(input int target);
		for (int i = 0; rise_cnt < target; i++) begin
			if (i > 4000) begin
				err_count++;
				results();
			end
			@(posedge ref_clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, mode_select_low, mode_select_high, ref_source_select} = 4'h0;
		{out_en_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		diff_in = '0;
		err_count = 0;
		checks_done = 0;
		repeat (3) @(posedge ref_clk);
		#1 chk_val({data_out, over_range_flag, standby, ref_internal_en, irq}, 16'h0006);
		// Release on a rising edge after three full cycles
		@(posedge ref_clk);
		rstn <= 1'b1;
		chk_reg(PAD_OFF_STATUS, 8'h00, 8'hff);
		chk_reg(PAD_OFF_MASK, 8'h00, 8'hff);
		// Gain one; never both pins high
		mode_select_low <= 1'b1;
		wait_to(rise_cnt + 8);
		chk_val(16'(standby), 16'h0000);
		// At least five samples taken under the new mode: fresh bit set
		chk_reg(PAD_OFF_MODE, 8'h0d, 8'h0f);
		// Conversion table, gain one then gain half
		for (int i = 0; i < 10; i++) begin
			if (i == 5) begin
				{mode_select_high, mode_select_low} <= PAD_PINS_GAIN_HALF;
				wait_to(rise_cnt + 4);
				// At most four samples since the change: fresh bit clear
				chk_reg(PAD_OFF_MODE, 8'h06, 8'h0f);
			end
			diff_in <= 14'(vals[i]);
			wait_to(rise_cnt + 8);
			chk_val({3'h0, cap_over, cap_word}, conv(vals[i], i > 4));
			chk_val({3'h0, over_range_flag, data_out}, conv(vals[i], i > 4));
			chk_val(16'(cap_valid), 16'h0001);
			chk_val(16'(irq), 16'h0000);
			if (i == 4) begin
				// Sticky over-range event, unmasked, then cleared by read
				reg_write(PAD_OFF_MASK, 8'h01);
				#1 chk_val(16'(irq), 16'h0001);
				chk_reg(PAD_OFF_STATUS, 8'h01, 8'h01);
				@(posedge ref_clk);
				#1 chk_val(16'(irq), 16'h0000);
				reg_write(PAD_OFF_MASK, 8'h00);
				// Step after a fall: old word at rise five, new at rise six
				@(negedge sample_clk);
				@(posedge ref_clk);
				diff_in <= 14'sd1000;
				k = rise_cnt + 1;
				wait_to(k + 5);
				chk_val({3'h0, cap_over, cap_word}, 16'h0800);
				wait_to(k + 6);
				chk_val({3'h0, cap_over, cap_word}, 16'h0be8);
			end
		end
		// Output enable acts without waiting for a clock edge
		out_en_n <= 1'b1;
		#1 chk_val(16'(data_oe), 16'h0000);
		@(posedge ref_clk);
		out_en_n <= 1'b0;
		#1 chk_val(16'(data_oe), 16'h0fff);
		// External reference strap
		ref_source_select <= 1'b1;
		wait_to(rise_cnt + 2);
		chk_val(16'(ref_internal_en), 16'h0000);
		chk_reg(PAD_OFF_MODE, 8'h00, 8'h04);
		// Standby freezes the outputs
		{mode_select_high, mode_select_low} <= 2'h0;
		wait_to(rise_cnt + 4);
		chk_val(16'(standby), 16'h0001);
		save = {3'h0, over_range_flag, data_out};
		diff_in <= 14'sd1234;
		wait_to(rise_cnt + 8);
		chk_val({3'h0, over_range_flag, data_out}, save);
		// Mode change and standby entry both recorded
		chk_reg(PAD_OFF_STATUS, 8'h06, 8'h06);
		// A mask write, then ignored writes to an unmapped address and the mode register, one idle cycle apart
		reg_write(PAD_OFF_MASK, 8'h05);
		reg_write(4'hc, 8'hff);
		reg_write(PAD_OFF_MODE, 8'hff);
		chk_reg(4'hc, 8'h00, 8'hff);
		chk_reg(PAD_OFF_MASK, 8'h05, 8'hff);
		chk_reg(PAD_OFF_MODE, 8'h00, 8'h03);
		results();
	end

endmodule

`default_nettype wire
